/* File: hdl/burst_counter.v */
// two-bit burst sequence generator, linear or interleaved
`default_nettype none
`include "burst_sram_defs.vh"
module burst_counter (
    input  wire [`CNT_W-1:0] i_start,
    input  wire [`CNT_W-1:0] i_step,
    input  wire              i_linear_order_n,
    output wire [`CNT_W-1:0] o_low_bits
);
    // interleaved: xor with step count; linear: add modulo four
    assign o_low_bits = i_linear_order_n ? (i_start ^ i_step) : (i_start + i_step);
endmodule // burst_counter
`default_nettype wire

/* File: hdl/burst_sram_defs.vh */
// constants for the pipelined burst sram port
`ifndef BURST_SRAM_DEFS_VH
`define BURST_SRAM_DEFS_VH
`define ADDR_W      20
`define DATA_W      32
`define BYTES       4
`define PIPE_DEPTH  2
`define BURST_LEN   4
`define CNT_W       2
`define CNT_ZERO    2'h0
`define CNT_ONE     2'h1
`define BYTE_W      8
`define DEPTH_LOG_DEFAULT 10
`endif

/* File: hdl/burst_sram_port.v */
// pipelined burst sram port: memory, burst counter, two-stage pipeline
// How it works
// - selected needs all three chip selects true
// - load read drives data two cycles later
// - load write data stored two cycles later
// - advance steps counter, four-word read burst
// - write burst takes four words, lag two
// - new load allowed on last burst word
// - clock enable high freezes every register
// - latency counts only enabled edges
// - deselect completes pending read, then high impedance
// - pending write completes despite deselect
// - data bus high impedance from first edge
// - counter wraps after fourth word, continues
// - order input picks interleaved or linear
// - advance keeps direction from the load
`default_nettype none
`include "burst_sram_defs.vh"
module burst_sram_port #(
    parameter ADDR_W    = `ADDR_W,
    parameter DEPTH_LOG = `DEPTH_LOG_DEFAULT,
    parameter DATA_W    = `DATA_W,
    parameter BYTES     = `BYTES
) (
    input  wire              i_clk_sys,
    input  wire              i_reset,
    input  wire              i_clock_enable_n,
    input  wire [ADDR_W-1:0] i_addr,
    input  wire              i_read_not_write,
    input  wire              i_advance_not_load,
    input  wire              i_chip_sel_a_n,
    input  wire              i_chip_sel_c_n,
    input  wire              i_chip_sel_b,
    input  wire [BYTES-1:0]  i_byte_write_n,
    input  wire              i_linear_order_n,
    input  wire              i_output_enable_n,
    input  wire [DATA_W-1:0] i_data,
    output wire [DATA_W-1:0] o_data,
    output wire              o_data_oe
);
    localparam PD    = `PIPE_DEPTH;
    localparam WORDS = 1 << DEPTH_LOG;
    // burst states, one-hot
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_READ  = 3'h2;
    localparam [2:0] ST_WRITE = 3'h4;

    // storage array, upper address bits ignored
    reg  [DATA_W-1:0]    mem [0:WORDS-1];

    // burst bookkeeping
    reg  [2:0]           state;
    reg  [2:0]           next_state;
    reg  [ADDR_W-1:0]    base_addr;
    reg  [ADDR_W-1:0]    next_base_addr;
    reg  [`CNT_W-1:0]    step;
    reg  [`CNT_W-1:0]    next_step;
    reg                  burst_active;
    reg                  burst_read;

    // operation entering the pipeline
    reg                  op_valid;
    reg                  op_read;
    reg  [ADDR_W-1:0]    op_addr;

    // pipeline stages: valid, read, address, byte enables
    reg  [PD-1:0]        pv;
    reg  [PD-1:0]        prd;
    reg  [ADDR_W-1:0]    pa0;
    reg  [ADDR_W-1:0]    pa1;
    reg  [BYTES-1:0]     pb0;
    reg  [BYTES-1:0]     pb1;

    // output stage and write lanes
    reg  [DATA_W-1:0]    q_data;
    reg                  q_drive;
    reg  [DATA_W-1:0]    wr_mask;

    wire                 enabled;
    wire                 selected;
    wire                 load_op;
    wire                 deselect_op;
    wire                 adv_op;
    wire [`CNT_W-1:0]    step_inc;
    wire [`CNT_W-1:0]    low_bits;
    wire                 xfer_valid;
    wire                 xfer_read;
    wire                 xfer_write;
    wire [DEPTH_LOG-1:0] xfer_index;
    integer              b;

    assign enabled     = ~i_clock_enable_n;
    assign selected    = ~i_chip_sel_a_n & ~i_chip_sel_c_n & i_chip_sel_b;
    assign load_op     = ~i_advance_not_load & selected;
    assign deselect_op = ~i_advance_not_load & ~selected;
    assign adv_op      = i_advance_not_load & burst_active;
    assign step_inc    = step + `CNT_ONE;

    burst_counter u_cnt (
        .i_start          (base_addr[`CNT_W-1:0]),
        .i_step           (step_inc),
        .i_linear_order_n (i_linear_order_n),
        .o_low_bits       (low_bits)
    );

    // stage two: transfer of the operation taken two enabled edges back
    assign xfer_valid = pv[PD-1];
    assign xfer_read  = xfer_valid & prd[PD-1];
    assign xfer_write = xfer_valid & ~prd[PD-1];
    assign xfer_index = pa1[DEPTH_LOG-1:0];

    // a load takes the pins, an advance keeps the loaded direction
    always @* begin
        op_valid = 1'b0;
        op_read  = burst_read;
        op_addr  = {base_addr[ADDR_W-1:`CNT_W], low_bits};
        if (load_op) begin
            op_valid = 1'b1;
            op_read  = i_read_not_write;
            op_addr  = i_addr;
        end else if (adv_op) begin
            op_valid = 1'b1;
        end
    end

    // burst state decode
    always @* begin
        burst_active = 1'b0;
        burst_read   = 1'b0;
        case (state)
            ST_IDLE: begin
                burst_active = 1'b0;
                burst_read   = 1'b0;
            end
            ST_READ: begin
                burst_active = 1'b1;
                burst_read   = 1'b1;
            end
            ST_WRITE: begin
                burst_active = 1'b1;
                burst_read   = 1'b0;
            end
            default: begin
                burst_active = 1'b0;
                burst_read   = 1'b0;
            end
        endcase
    end

    // load restarts a burst, deselect ends it, advance steps it
    always @* begin
        next_state     = state;
        next_base_addr = base_addr;
        next_step      = step;
        if (load_op) begin
            next_base_addr = i_addr;
            next_step      = `CNT_ZERO;
            if (i_read_not_write)
                next_state = ST_READ;
            else
                next_state = ST_WRITE;
        end else if (deselect_op) begin
            next_state = ST_IDLE;
        end else if (adv_op) begin
            next_step = step_inc;
        end
    end

    // burst registers, frozen on suspended edges
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            state     <= ST_IDLE;
            base_addr <= {ADDR_W{1'b0}};
            step      <= `CNT_ZERO;
        end else if (enabled) begin
            state     <= next_state;
            base_addr <= next_base_addr;
            step      <= next_step;
        end
    end

    // address pipeline, moves only on enabled edges
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            pv  <= {PD{1'b0}};
            prd <= {PD{1'b0}};
            pa0 <= {ADDR_W{1'b0}};
            pa1 <= {ADDR_W{1'b0}};
            pb0 <= {BYTES{1'b1}};
            pb1 <= {BYTES{1'b1}};
        end else if (enabled) begin
            pv  <= {pv[PD-2:0], op_valid};
            prd <= {prd[PD-2:0], op_read};
            pa0 <= op_addr;
            pa1 <= pa0;
            pb0 <= i_byte_write_n;
            pb1 <= pb0;
        end
    end

    // output stage, independent of the selects
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            q_data  <= {DATA_W{1'b0}};
            q_drive <= 1'b0;
        end else if (enabled) begin
            q_drive <= xfer_read;
            if (xfer_read)
                q_data <= mem[xfer_index];
        end
    end

    // byte lanes of a write, from the enables taken with its address
    always @* begin
        wr_mask = {DATA_W{1'b0}};
        for (b = 0; b < BYTES; b = b + 1) begin
            wr_mask[b*`BYTE_W +: `BYTE_W] = {`BYTE_W{~pb1[b]}};
        end
    end

    // write commits in the cycle its data arrives, two enabled edges on
    always @(posedge i_clk_sys) begin
        if (!i_reset && enabled && xfer_write)
            mem[xfer_index] <= (mem[xfer_index] & ~wr_mask) | (i_data & wr_mask);
    end

    assign o_data    = q_data;
    assign o_data_oe = q_drive & ~i_output_enable_n;
endmodule // burst_sram_port
`default_nettype wire

/* File: testbench/burst_sram_port_properties.sv */
// pin-level assertions for the burst sram port
`default_nettype none
module burst_sram_port_properties (
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire logic        i_clock_enable_n,
    input wire logic        i_read_not_write,
    input wire logic        i_advance_not_load,
    input wire logic        i_chip_sel_a_n,
    input wire logic        i_chip_sel_c_n,
    input wire logic        i_chip_sel_b,
    input wire logic        i_output_enable_n,
    input wire logic        o_data_oe,
    input wire logic [31:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    wire run = !i_clock_enable_n;
    wire en  = !i_output_enable_n;
    wire sel = !i_chip_sel_a_n && !i_chip_sel_c_n && i_chip_sel_b;
    wire ld  = run && !i_advance_not_load;
    sequence rd_load; ld && sel && i_read_not_write; endsequence
    sequence wr_load; ld && sel && !i_read_not_write; endsequence
    AST_OE_GATED: assert property (o_data_oe |-> en)
        else $error("bus driven while output enable is off");
    AST_HOLD_DATA: assert property (!run |=> $stable(o_data))
        else $error("read data moved on a frozen edge");
    AST_READ_TWO: assert property (rd_load ##1 run ##1 run ##1 en |-> o_data_oe)
        else $error("read not driven two edges after load");
    AST_WRITE_Z: assert property (wr_load ##1 run ##1 run |=> !o_data_oe)
        else $error("bus driven in a write data cycle");
    AST_DESEL_Z: assert property (ld && !sel ##1 run ##1 run |=> !o_data_oe)
        else $error("bus driven after deselect");
    AST_NOOP_Z: assert property (ld && !sel ##1 run && i_advance_not_load ##1 run ##1 run |=> !o_data_oe)
        else $error("advance after deselect drove the bus");
    AST_SUSPEND: assert property (rd_load ##1 !run ##1 run ##1 run ##1 en |-> o_data_oe)
        else $error("suspended read not delayed by one edge");
    AST_BURST: assert property (rd_load ##1 (run && i_advance_not_load)[*3] ##1 run ##1 run ##1 en |-> o_data_oe)
        else $error("fourth burst word not driven");
endmodule // burst_sram_port_properties
bind burst_sram_port burst_sram_port_properties props (
    .i_clk_sys          (i_clk_sys),
    .i_reset            (i_reset),
    .i_clock_enable_n   (i_clock_enable_n),
    .i_read_not_write   (i_read_not_write),
    .i_advance_not_load (i_advance_not_load),
    .i_chip_sel_a_n     (i_chip_sel_a_n),
    .i_chip_sel_c_n     (i_chip_sel_c_n),
    .i_chip_sel_b       (i_chip_sel_b),
    .i_output_enable_n  (i_output_enable_n),
    .o_data_oe          (o_data_oe),
    .o_data             (o_data)
);
`default_nettype wire

/* File: testbench/burst_sram_port_tb_top.sv */
// self-checking bench for the burst sram port
`default_nettype none
module burst_sram_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 0, i_reset = 1, i_clock_enable_n = 0, i_read_not_write = 0, i_advance_not_load = 0, wr = 0;
    logic i_chip_sel_a_n = 0, i_chip_sel_c_n = 0, i_chip_sel_b = 1, i_linear_order_n = 0, i_output_enable_n = 0;
    logic [19:0] i_addr = 0;
    logic [31:0] mem [16], wd = 0, xe = 0;
    logic [3:0]  i_byte_write_n = 0, a1, a2, m1, m2, ba;
    logic [1:0]  ct;
    logic        act = 0, dir = 0, v1 = 0, v2 = 0, r1 = 0, r2 = 0, xr = 0;
    wire logic [31:0] i_data, o_data;
    wire logic   o_data_oe;
    wire         sel = !i_chip_sel_a_n && !i_chip_sel_c_n && i_chip_sel_b;
    int          mismatches = 0, total_checks = 0;
    ctrl_data_model pm (.i_clk_sys, .i_clock_enable_n, .i_write(wr), .i_word(wd), .o_word(i_data));
    burst_sram_port #(.DEPTH_LOG(4)) dut (
        .i_clk_sys          (i_clk_sys),
        .i_reset            (i_reset),
        .i_clock_enable_n   (i_clock_enable_n),
        .i_addr             (i_addr),
        .i_read_not_write   (i_read_not_write),
        .i_advance_not_load (i_advance_not_load),
        .i_chip_sel_a_n     (i_chip_sel_a_n),
        .i_chip_sel_c_n     (i_chip_sel_c_n),
        .i_chip_sel_b       (i_chip_sel_b),
        .i_byte_write_n     (i_byte_write_n),
        .i_linear_order_n   (i_linear_order_n),
        .i_output_enable_n  (i_output_enable_n),
        .i_data             (i_data),
        .o_data             (o_data),
        .o_data_oe          (o_data_oe)
    );
    initial forever #2 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            {act, v1, v2, xr} = 4'h0;
        end else if (!i_clock_enable_n) begin
            xr = v2 && r2;
            if (v2 && !r2) for (int b = 0; b < 4; b++) if (!m2[b]) mem[a2][8*b+:8] = i_data[8*b+:8];
            xe = mem[a2];
            {v2, r2, a2, m2} = {v1, r1, a1, m1};
            if (!i_advance_not_load) begin
                act = sel;
                {dir, ba, ct} = {i_read_not_write, i_addr[3:0], 2'h0};
            end else ct = ct + 2'h1;
            {v1, r1, m1} = {act, dir, i_byte_write_n};
            a1 = {ba[3:2], i_linear_order_n ? ba[1:0] ^ ct : ba[1:0] + ct};
        end
    end
    task automatic chk;
        total_checks++;
        if (o_data_oe !== (xr && !i_output_enable_n) || (o_data_oe && o_data !== xe)) begin
            mismatches++;
            $display("CHECK FAILED drive/data expected %b/%h seen %b/%h", xr && !i_output_enable_n, xe, o_data_oe, o_data);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(32'ha350));
        repeat (5) @(negedge i_clk_sys);
        i_reset = 0;
        for (int i = 0; i < 400; i++) begin
            @(negedge i_clk_sys);
            chk;
            i_clock_enable_n = i > 16 && $urandom % 5 == 0;
            i_advance_not_load = i < 16 ? i % 4 != 0 : $urandom % 2;
            i_read_not_write = i > 16 && $urandom % 2;
            {i_chip_sel_a_n, i_chip_sel_c_n, i_chip_sel_b} = i < 16 || $urandom % 3 ? 3'h1 : 3'($urandom);
            i_addr = i < 16 ? 20'(i) : 20'($urandom);
            i_byte_write_n = i < 16 ? 4'h0 : 4'($urandom);
            i_output_enable_n = i > 16 && $urandom % 8 == 0;
            if (!i_advance_not_load) i_linear_order_n = i > 16 && $urandom % 2;
            wd = $urandom;
            wr = i_advance_not_load ? act && !dir
                                    : !i_chip_sel_a_n && !i_chip_sel_c_n && i_chip_sel_b && !i_read_not_write;
        end
        report_and_stop;
    end
endmodule // burst_sram_port_tb_top
`default_nettype wire

/* File: testbench/ctrl_data_model.sv */
// controller-side write data: word two enabled edges after its address edge
`default_nettype none
module ctrl_data_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_clock_enable_n,
    input  wire logic        i_write,
    input  wire logic [31:0] i_word,
    output var  logic [31:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] d1, d2;
    logic        v1 = 0, v2 = 0;
    initial o_word = 32'h0;
    always @(posedge i_clk_sys) if (!i_clock_enable_n) {v2, d2, v1, d1} <= {v1, d1, i_write, i_word};
    // released bus inverts every bit on each falling edge, so the last word returns every other cycle
    always @(negedge i_clk_sys) o_word <= v2 ? d2 : ~o_word;
endmodule // ctrl_data_model
`default_nettype wire
